// ==== rtsc_pkg.sv ====
// Shared constants for the reader timer section
package rtsc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_RUN_CONTROL  = 8'h0E;
  localparam logic [7:0] ADDR_T0_MODE      = 8'h0F;
  localparam logic [7:0] ADDR_T0_RELOAD_HI = 8'h10;
  localparam logic [7:0] ADDR_T0_RELOAD_LO = 8'h11;
  localparam logic [7:0] ADDR_T0_COUNT_HI  = 8'h12;
  localparam logic [7:0] ADDR_T0_COUNT_LO  = 8'h13;
  localparam logic [7:0] ADDR_T1_MODE      = 8'h14;
  localparam logic [7:0] ADDR_T1_RELOAD_HI = 8'h15;
  localparam logic [7:0] ADDR_T1_RELOAD_LO = 8'h16;
  localparam logic [7:0] ADDR_T1_COUNT_HI  = 8'h17;
  localparam logic [7:0] ADDR_T1_COUNT_LO  = 8'h18;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h20;

  // Run control layout
  localparam int RUN_FLAG_LSB  = 4;
  localparam int RUN_MASK_LSB  = 0;
  localparam int TIMER_COUNT   = 4;

  // Mode register layout
  localparam int MODE_HALT_BIT    = 7;
  localparam int MODE_LAUNCH_LSB  = 4;
  localparam int MODE_RELOAD_BIT  = 3;
  localparam int MODE_TICK_LSB    = 0;
  localparam logic [7:0] MODE_IMPL_MASK = 8'hBB;

  // Event status layout
  localparam int STATUS_T1_UNDERFLOW_BIT = 0;

  // Launch modes
  localparam logic [1:0] LAUNCH_SOFTWARE  = 2'b00;
  localparam logic [1:0] LAUNCH_TX_END    = 2'b01;
  localparam logic [1:0] LAUNCH_TRIM_HOLD = 2'b10;
  localparam logic [1:0] LAUNCH_TRIM_WRAP = 2'b11;

  // Tick sources
  localparam logic [1:0] TICK_FAST   = 2'b00;
  localparam logic [1:0] TICK_SLOW   = 2'b01;
  localparam logic [1:0] TICK_CASC_A = 2'b10;
  localparam logic [1:0] TICK_CASC_B = 2'b11;

  // Reset values
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [7:0]  RDATA_RESET  = 8'h00;
endpackage

// ==== rtsc_timer_chan.sv ====
// One 16-bit down-counting timer channel
`timescale 1ns/1ps
module rtsc_timer_chan (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // Configuration
  input  wire logic [7:0]  i_mode,
  input  wire logic [15:0] i_reload,
  // Software control
  input  wire logic        i_sw_start,
  input  wire logic        i_sw_stop,
  // Tick sources
  input  wire logic        i_tick_fast,
  input  wire logic        i_tick_slow,
  input  wire logic        i_casc_a,
  input  wire logic        i_casc_b,
  // Transceiver events
  input  wire logic        i_tx_done,
  input  wire logic        i_rx_nibble,
  input  wire logic        i_trim_ref,
  // Status
  output logic [15:0]      o_count,
  output logic             o_running,
  output logic             o_underflow
);
  typedef struct packed {
    logic [15:0] count;
    logic        running;
    logic        trim_prev;
    logic        underflow;
  } rtsc_chan_t;

  rtsc_chan_t r;
  rtsc_chan_t next_r;

  logic [1:0] launch;
  logic [1:0] tick_sel;
  logic       trim;
  logic       ref_rise;
  logic       tick;
  logic       start_evt;
  logic       stop_evt;

  always_comb begin
    launch   = i_mode[rtsc_pkg::MODE_LAUNCH_LSB +: 2];
    tick_sel = i_mode[rtsc_pkg::MODE_TICK_LSB +: 2];
    trim     = launch[1];
    ref_rise = i_trim_ref & ~r.trim_prev;
    case (tick_sel)
      rtsc_pkg::TICK_FAST:   tick = i_tick_fast;
      rtsc_pkg::TICK_SLOW:   tick = i_tick_slow;
      rtsc_pkg::TICK_CASC_A: tick = i_casc_a;
      rtsc_pkg::TICK_CASC_B: tick = i_casc_b;
      default:               tick = 1'b0;
    endcase
    // Automatic starts only in the tx-end and trimming modes
    start_evt = i_sw_start
              | ((launch == rtsc_pkg::LAUNCH_TX_END) & i_tx_done)
              | (trim & ref_rise & ~r.running);
    stop_evt  = i_sw_stop
              | (~trim & i_mode[rtsc_pkg::MODE_HALT_BIT] & i_rx_nibble)
              | (trim & ref_rise & r.running);

    next_r           = r;
    next_r.trim_prev = i_trim_ref;
    next_r.underflow = 1'b0;
    if (start_evt) begin
      next_r.count   = i_reload;
      next_r.running = 1'b1;
    end else if (stop_evt) begin
      next_r.running = 1'b0;
    end else if (r.running && tick) begin
      if (r.count != rtsc_pkg::COUNT_ZERO) begin
        next_r.count = r.count - 16'h0001;
      end else if (launch == rtsc_pkg::LAUNCH_TRIM_HOLD) begin
        next_r.count = rtsc_pkg::COUNT_ZERO;
      end else begin
        next_r.underflow = 1'b1;
        if (i_mode[rtsc_pkg::MODE_RELOAD_BIT]) begin
          next_r.count = i_reload;
        end else begin
          next_r.running = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_count     = r.count;
  assign o_running   = r.running;
  assign o_underflow = r.underflow;
endmodule

// ==== rtsc_timer_section.sv ====
// Reader timer section: run control, timer0/timer1 registers and counters
// Operation
// - Low nibble of run-control write masks which run flags take written bits.
// - Writing FFh sets all run flags; F0h changes none.
// - Run flags show counting; setting starts, clearing stops the timer.
// - Mask bits are write-only; bit n gates timer n run flag.
// - Halt-on-receive stops the timer after the first 4 received bits.
// - Halt-on-receive is ignored in trimming modes.
// - Launch mode 00b: only software starts the timer.
// - Launch mode 01b: timer starts when transmission ends.
// - Launch mode 10b: trimming, no underflow, start/stop on reference rising edge.
// - Launch mode 11b: trimming with underflow, start/stop on rising edges.
// - Reload-on-zero set: counter reloads and keeps counting at zero.
// - Reload-on-zero clear: counter counts to zero then stops.
// - Timer1 underflow sets its interrupt request flag.
// - Tick select 00b counts 13.56 MHz ticks, 01b 211.875 kHz ticks.
// - Timer1 tick select 10b counts timer0 underflows, 11b timer2 underflows.
// - Each start loads the counter from the 16-bit reload value.
// - Reload writes do not disturb a running count; used at next start.
// - Timer0 count readable as two dynamic read-only bytes.
`timescale 1ns/1ps
module rtsc_timer_section (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  // Count ticks, one-cycle pulses
  input  wire logic       i_tick_fast,
  input  wire logic       i_tick_slow,
  // Transceiver events, one-cycle pulses
  input  wire logic       i_tx_done,
  input  wire logic       i_rx_nibble,
  // Trimming reference level
  input  wire logic       i_trim_ref,
  // Timer2 and timer3 interface
  input  wire logic       i_timer2_underflow,
  input  wire logic       i_timer2_stopped,
  input  wire logic       i_timer3_stopped,
  output logic            o_timer2_active_flag,
  output logic            o_timer3_active_flag,
  // Timer status
  output logic            o_timer0_underflow,
  output logic            o_timer1_underflow,
  output logic            o_timer1_underflow_request
);
  typedef struct packed {
    logic [7:0]  timer0_mode;
    logic [7:0]  timer1_mode;
    logic [15:0] timer0_preset_value;
    logic [15:0] timer1_preset_value;
    logic        timer2_active_flag;
    logic        timer3_active_flag;
    logic        timer1_underflow_request;
    logic [7:0]  rdata;
  } rtsc_regs_t;

  rtsc_regs_t r;
  rtsc_regs_t next_r;

  logic [3:0]  flag_write_mask;
  logic [3:0]  flag_write_value;
  logic [3:0]  sw_start;
  logic [3:0]  sw_stop;
  logic        ctrl_wr;
  logic [15:0] timer0_count;
  logic [15:0] timer1_count;
  logic        timer0_active_flag;
  logic        timer1_active_flag;
  logic        timer0_uf;
  logic        timer1_uf;
  logic [3:0]  active_flags;
  logic [7:0]  rd_value;

  // Masked start/stop decode of the run-control write
  always_comb begin
    ctrl_wr          = i_wr & (i_addr == rtsc_pkg::ADDR_RUN_CONTROL);
    flag_write_mask  = i_wdata[rtsc_pkg::RUN_MASK_LSB +: rtsc_pkg::TIMER_COUNT];
    flag_write_value = i_wdata[rtsc_pkg::RUN_FLAG_LSB +: rtsc_pkg::TIMER_COUNT];
    sw_start = {4{ctrl_wr}} & flag_write_mask & flag_write_value;
    sw_stop  = {4{ctrl_wr}} & flag_write_mask & ~flag_write_value;
  end

  rtsc_timer_chan u_timer0 (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_mode      (r.timer0_mode),
    .i_reload    (r.timer0_preset_value),
    .i_sw_start  (sw_start[0]),
    .i_sw_stop   (sw_stop[0]),
    .i_tick_fast (i_tick_fast),
    .i_tick_slow (i_tick_slow),
    .i_casc_a    (timer1_uf),
    .i_casc_b    (i_timer2_underflow),
    .i_tx_done   (i_tx_done),
    .i_rx_nibble (i_rx_nibble),
    .i_trim_ref  (i_trim_ref),
    .o_count     (timer0_count),
    .o_running   (timer0_active_flag),
    .o_underflow (timer0_uf)
  );

  rtsc_timer_chan u_timer1 (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_mode      (r.timer1_mode),
    .i_reload    (r.timer1_preset_value),
    .i_sw_start  (sw_start[1]),
    .i_sw_stop   (sw_stop[1]),
    .i_tick_fast (i_tick_fast),
    .i_tick_slow (i_tick_slow),
    .i_casc_a    (timer0_uf),
    .i_casc_b    (i_timer2_underflow),
    .i_tx_done   (i_tx_done),
    .i_rx_nibble (i_rx_nibble),
    .i_trim_ref  (i_trim_ref),
    .o_count     (timer1_count),
    .o_running   (timer1_active_flag),
    .o_underflow (timer1_uf)
  );

  assign active_flags = {r.timer3_active_flag, r.timer2_active_flag,
                         timer1_active_flag, timer0_active_flag};

  // Read multiplexer; mask nibble reads as zero
  always_comb begin
    case (i_addr)
      rtsc_pkg::ADDR_RUN_CONTROL:  rd_value = {active_flags, 4'h0};
      rtsc_pkg::ADDR_T0_MODE:      rd_value = r.timer0_mode;
      rtsc_pkg::ADDR_T0_RELOAD_HI: rd_value = r.timer0_preset_value[15:8];
      rtsc_pkg::ADDR_T0_RELOAD_LO: rd_value = r.timer0_preset_value[7:0];
      rtsc_pkg::ADDR_T0_COUNT_HI:  rd_value = timer0_count[15:8];
      rtsc_pkg::ADDR_T0_COUNT_LO:  rd_value = timer0_count[7:0];
      rtsc_pkg::ADDR_T1_MODE:      rd_value = r.timer1_mode;
      rtsc_pkg::ADDR_T1_RELOAD_HI: rd_value = r.timer1_preset_value[15:8];
      rtsc_pkg::ADDR_T1_RELOAD_LO: rd_value = r.timer1_preset_value[7:0];
      rtsc_pkg::ADDR_T1_COUNT_HI:  rd_value = timer1_count[15:8];
      rtsc_pkg::ADDR_T1_COUNT_LO:  rd_value = timer1_count[7:0];
      rtsc_pkg::ADDR_EVENT_STATUS: begin
        rd_value = 8'h00;
        rd_value[rtsc_pkg::STATUS_T1_UNDERFLOW_BIT] = r.timer1_underflow_request;
      end
      default:                     rd_value = 8'h00;
    endcase
  end

  always_comb begin
    next_r       = r;
    next_r.rdata = i_rd ? rd_value : rtsc_pkg::RDATA_RESET;

    if (i_wr) begin
      case (i_addr)
        rtsc_pkg::ADDR_T0_MODE:
          next_r.timer0_mode = i_wdata & rtsc_pkg::MODE_IMPL_MASK;
        rtsc_pkg::ADDR_T1_MODE:
          next_r.timer1_mode = i_wdata & rtsc_pkg::MODE_IMPL_MASK;
        rtsc_pkg::ADDR_T0_RELOAD_HI: next_r.timer0_preset_value[15:8] = i_wdata;
        rtsc_pkg::ADDR_T0_RELOAD_LO: next_r.timer0_preset_value[7:0]  = i_wdata;
        rtsc_pkg::ADDR_T1_RELOAD_HI: next_r.timer1_preset_value[15:8] = i_wdata;
        rtsc_pkg::ADDR_T1_RELOAD_LO: next_r.timer1_preset_value[7:0]  = i_wdata;
        default: ;
      endcase
    end

    // Timer2 and timer3 flags: outer timers report their own stops
    if (sw_start[2]) begin
      next_r.timer2_active_flag = 1'b1;
    end else if (sw_stop[2] || i_timer2_stopped) begin
      next_r.timer2_active_flag = 1'b0;
    end
    if (sw_start[3]) begin
      next_r.timer3_active_flag = 1'b1;
    end else if (sw_stop[3] || i_timer3_stopped) begin
      next_r.timer3_active_flag = 1'b0;
    end

    // Write-one-to-clear; a new underflow in the same cycle wins
    if (i_wr && (i_addr == rtsc_pkg::ADDR_EVENT_STATUS) &&
        i_wdata[rtsc_pkg::STATUS_T1_UNDERFLOW_BIT]) begin
      next_r.timer1_underflow_request = 1'b0;
    end
    if (timer1_uf) begin
      next_r.timer1_underflow_request = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r.timer0_mode              <= rtsc_pkg::MODE_RESET;
      r.timer1_mode              <= rtsc_pkg::MODE_RESET;
      r.timer0_preset_value      <= rtsc_pkg::RELOAD_RESET;
      r.timer1_preset_value      <= rtsc_pkg::RELOAD_RESET;
      r.timer2_active_flag       <= 1'b0;
      r.timer3_active_flag       <= 1'b0;
      r.timer1_underflow_request <= 1'b0;
      r.rdata                    <= rtsc_pkg::RDATA_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata                    = r.rdata;
  assign o_timer2_active_flag       = r.timer2_active_flag;
  assign o_timer3_active_flag       = r.timer3_active_flag;
  assign o_timer0_underflow         = timer0_uf;
  assign o_timer1_underflow         = timer1_uf;
  assign o_timer1_underflow_request = r.timer1_underflow_request;
endmodule

// ==== rtsc_far_end.sv ====
// Far-side model: count ticks, transceiver events and external timers
`timescale 1ns/1ps
module rtsc_far_end (
  // Clock, reset and bench commands
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_fast_on,
  input  wire logic       i_t2_on,
  input  wire logic [3:0] i_cmd,
  // Toward the timer section
  output logic            o_tick_fast,
  output logic            o_tick_slow,
  output logic            o_tx_done,
  output logic            o_rx_nibble,
  output logic            o_trim_ref,
  output logic            o_t2_unf,
  output logic            o_stopped
);
  logic [5:0] div;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      {div, o_tick_fast, o_tick_slow, o_t2_unf} <= '0;
      {o_stopped, o_trim_ref, o_rx_nibble, o_tx_done} <= '0;
    end else begin
      div <= div + 6'h01;
      o_tick_fast <= i_fast_on;
      o_tick_slow <= div == 6'h00;
      o_t2_unf <= i_t2_on && div[2:0] == 3'h0;
      // One-cycle event pulses; the reference is a level
      {o_stopped, o_trim_ref, o_rx_nibble, o_tx_done} <= i_cmd;
    end
  end
endmodule

// ==== rtsc_timer_section_asserts.sv ====
// Run-control and request-flag checks for the timer section
`timescale 1ns/1ps
module rtsc_timer_section_asserts (
  // Clock, reset and register port
  input wire logic       i_mclk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // External timers and status
  input wire logic       i_timer2_stopped,
  input wire logic       i_timer3_stopped,
  input wire logic       o_timer2_active_flag,
  input wire logic       o_timer3_active_flag,
  input wire logic       o_timer1_underflow,
  input wire logic       o_timer1_underflow_request
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire ctl_wr = i_wr && i_addr == rtsc_pkg::ADDR_RUN_CONTROL;
  wire clr_wr = i_wr && i_addr == rtsc_pkg::ADDR_EVENT_STATUS && i_wdata[0];
  ctrl_nibble_a: assert property (i_rd && i_addr == 8'h0E |=> o_rdata[3:0] == 4'h0)
    else $error("mask nibble not read as zero");
  t2_set_a: assert property (ctl_wr && i_wdata[2] |=> o_timer2_active_flag == $past(i_wdata[6]))
    else $error("timer2 flag ignored its mask");
  t2_keep_a: assert property (ctl_wr && !i_wdata[2] && !i_timer2_stopped
    |=> $stable(o_timer2_active_flag)) else $error("timer2 flag changed while masked");
  t3_set_a: assert property (ctl_wr && i_wdata[3] |=> o_timer3_active_flag == $past(i_wdata[7]))
    else $error("timer3 flag ignored its mask");
  t3_stop_a: assert property (i_timer3_stopped && !(ctl_wr && i_wdata[3] && i_wdata[7])
    |=> !o_timer3_active_flag) else $error("timer3 flag kept after stop");
  req_set_a: assert property (o_timer1_underflow && !clr_wr |=> o_timer1_underflow_request)
    else $error("underflow did not raise request");
  req_hold_a: assert property (o_timer1_underflow_request && !clr_wr |=>
    o_timer1_underflow_request) else $error("request dropped without clear");
  req_clear_a: assert property (clr_wr && !o_timer1_underflow |=>
    !o_timer1_underflow_request) else $error("request not cleared");
endmodule
bind rtsc_timer_section rtsc_timer_section_asserts chk_u (.i_mclk, .i_rstn, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_timer2_stopped, .i_timer3_stopped, .o_timer2_active_flag,
  .o_timer3_active_flag, .o_timer1_underflow, .o_timer1_underflow_request);

// ==== rtsc_timer_section_tb.sv ====
// Self-checking bench for the timer section
`timescale 1ns/1ps
module rtsc_timer_section_tb;
  logic        i_mclk, i_rstn, i_wr, i_rd, fast_on, t2_on;
  logic [3:0]  cmd;
  logic [7:0]  i_addr, i_wdata, e;
  logic [15:0] rv;
  logic [31:0] r, seed = 32'h5b72;
  wire logic [7:0] o_rdata;
  wire logic   i_tick_fast, i_tick_slow, i_tx_done, i_rx_nibble, i_trim_ref;
  wire logic   i_timer2_underflow, i_timer2_stopped, i_timer3_stopped, o_timer0_underflow;
  wire logic   o_timer2_active_flag, o_timer3_active_flag, o_timer1_underflow;
  wire logic   o_timer1_underflow_request;
  int          bad_count, total_checks, n, k;
  // Launch table: mode byte, event command, expected timer0 flag
  logic [15:0] steps [12] = '{16'h8010, 16'h9011, 16'h9020, 16'h1011, 16'h1021, 16'hA040,
                              16'hA041, 16'hA021, 16'hA040, 16'hB041, 16'hB021, 16'hB040};
  assign i_timer3_stopped = i_timer2_stopped;
  rtsc_far_end far_u (.i_mclk, .i_rstn, .i_fast_on(fast_on), .i_t2_on(t2_on), .i_cmd(cmd),
    .o_tick_fast(i_tick_fast), .o_tick_slow(i_tick_slow), .o_tx_done(i_tx_done),
    .o_rx_nibble(i_rx_nibble), .o_trim_ref(i_trim_ref), .o_t2_unf(i_timer2_underflow),
    .o_stopped(i_timer2_stopped));
  rtsc_timer_section dut_u (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_tick_fast, .i_tick_slow, .i_tx_done, .i_rx_nibble, .i_trim_ref, .i_timer2_underflow,
    .i_timer2_stopped, .i_timer3_stopped, .o_timer2_active_flag, .o_timer3_active_flag,
    .o_timer0_underflow, .o_timer1_underflow, .o_timer1_underflow_request);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Run flags after a masked control write
  function automatic logic [7:0] run_exp(input logic [7:0] old, w);
    return (old & ~{w[3:0], 4'h0}) | (w & {w[3:0], 4'h0});
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, g, x);
    end
  endtask
  // One register cycle; a read compares the data of the following cycle
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge i_mclk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1;
    if (!w) chk(o_rdata, d);
  endtask
  task automatic ev(input logic [3:0] c);
    @(posedge i_mclk);
    cmd <= c;
    @(posedge i_mclk);
    cmd <= 4'h0;
    repeat (2) @(posedge i_mclk);
  endtask
  // Edges until the next underflow pulse of timer0 or timer1
  task automatic gap(input logic t1, output int c);
    c = 0;
    do begin
      @(posedge i_mclk);
      #1;
      c++;
    end while ((t1 ? o_timer1_underflow : o_timer0_underflow) !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      bad_count++;
      results();
    end
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    {i_rstn, i_wr, i_rd, fast_on, t2_on, cmd} = '0;
    {i_addr, i_wdata, e} = '0;
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'b1;
    bus(1'b0, 8'h30, 8'h00);
    bus(1'b0, 8'h14, rtsc_pkg::MODE_RESET);
    for (k = 0; k < 3; k++) begin
      r = xs();
      bus(1'b1, 8'h0F, r[7:0]);
      bus(1'b1, 8'h14, r[15:8]);
      bus(1'b0, 8'h0F, r[7:0] & rtsc_pkg::MODE_IMPL_MASK);
      bus(1'b0, 8'h14, r[15:8] & rtsc_pkg::MODE_IMPL_MASK);
    end
    bus(1'b1, 8'h0F, 8'h00);
    bus(1'b1, 8'h14, 8'h00);
    for (k = 0; k < 10; k++) begin
      r = (k == 8) ? 32'hFF : (k == 9) ? 32'hF0 : xs();
      bus(1'b1, 8'h0E, r[7:0]);
      e = run_exp(e, r[7:0]);
      bus(1'b0, 8'h0E, e);
    end
    ev(4'h8);
    bus(1'b0, 8'h0E, 8'h30);
    bus(1'b1, 8'h0E, 8'h0F);
    bus(1'b1, 8'h10, 8'h01);
    foreach (steps[i]) begin
      bus(1'b1, 8'h0F, steps[i][15:8]);
      ev(steps[i][7:4]);
      bus(1'b0, 8'h0E, {steps[i][3:0], 4'h0});
    end
    fast_on <= 1'b1;
    r = xs();
    rv = {13'h0000, r[2:0]} + 16'h0003;
    bus(1'b1, 8'h0F, 8'h00);
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b1, 8'h11, rv[7:0]);
    bus(1'b1, 8'h0E, 8'h11);
    bus(1'b1, 8'h11, 8'h40);
    gap(1'b0, n);
    // Underflow is rv+1 ticks after the start edge; two edges went by before the wait
    chk(16'(n + 2), rv + 16'h0001);
    bus(1'b0, 8'h0E, 8'h00);
    // Trimming without underflow holds at zero and keeps running
    bus(1'b1, 8'h0F, 8'h20);
    bus(1'b1, 8'h0E, 8'h11);
    repeat (80) @(posedge i_mclk);
    bus(1'b0, 8'h0E, 8'h10);
    bus(1'b0, 8'h13, 8'h00);
    bus(1'b1, 8'h0E, 8'h01);
    bus(1'b1, 8'h0F, 8'h00);
    fast_on <= 1'b0;
    bus(1'b1, 8'h10, r[15:8]);
    bus(1'b1, 8'h0E, 8'h11);
    // Count is read with no reception under way
    bus(1'b0, 8'h13, 8'h40);
    bus(1'b0, 8'h12, r[15:8]);
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b1, 8'h11, rv[7:0]);
    fast_on <= 1'b1;
    for (k = 0; k < 2; k++) begin
      bus(1'b1, 8'h0F, k ? 8'h09 : 8'h08);
      bus(1'b1, 8'h0E, 8'h11);
      gap(1'b0, n);
      gap(1'b0, n);
      chk(16'(n), k ? (rv + 16'h0001) * 16'h0040 : rv + 16'h0001);
    end
    t2_on <= 1'b1;
    bus(1'b1, 8'h16, 8'h01);
    bus(1'b1, 8'h0F, 8'h08);
    for (k = 0; k < 2; k++) begin
      bus(1'b1, 8'h14, k ? 8'h0B : 8'h0A);
      bus(1'b1, 8'h0E, 8'h33);
      gap(1'b1, n);
      gap(1'b1, n);
      chk(16'(n), k ? 16'h0010 : (rv + 16'h0001) * 16'h0002);
    end
    bus(1'b0, 8'h20, 8'h01);
    bus(1'b1, 8'h0E, 8'h03);
    bus(1'b1, 8'h20, 8'h01);
    bus(1'b0, 8'h20, 8'h00);
    results();
  end
endmodule
